//--- rtl/bst_regs.svh
// Constants for the boundary-scan test port: codes, lengths, chain positions.
`ifndef BST_REGS_SVH
`define BST_REGS_SVH
`define BST_IR_LEN       3
`define BST_IR_CAPTURE   3'h5
`define BST_IR_EXTEST    3'h0
`define BST_IR_SAMPLE    3'h1
`define BST_IR_IDCODE    3'h2
`define BST_IR_VTEST     3'h3
`define BST_IR_HIGHZ     3'h4
`define BST_IR_CLAMP     3'h6
`define BST_CHAIN_LEN    29
`define BST_VT_LEN       8
`define BST_ID_LEN       32
`define BST_N_IN         8
`define BST_POS_SDA_OUT  8
`define BST_POS_SDA_IN   9
`define BST_POS_OEL_EN   10
`define BST_POS_OEL_OUT  11
`define BST_POS_A_EN     12
`define BST_POS_A_BASE   13
`define BST_OUT_MASK     29'haaabd00
`define BST_ID_PAD       4'h0
`define BST_VT_RESET     8'h00
`define BST_BYP_CAPTURE  1'h0
`endif

//--- rtl/bst_pkg.sv
// Types shared by the boundary-scan test port.
`default_nettype none
package bst_pkg;
  typedef enum logic [3:0] {
    TLR, RTI,
    SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } bst_tap_state_t;
endpackage
`default_nettype wire

//--- rtl/bst_tap.sv
// Boundary-scan test access port with its chain, identification and test registers.
//
// Summary of operation
// - Four pins only; power-on reset forces Test-Logic-Reset.
// - Standard TAP machine sequences capture, shift, update.
// - IR branch shifts IR; otherwise selected data register.
// - Instruction register three bits, no parity.
// - Capture-IR loads fixed pattern 101.
// - Decode codes; unassigned upper codes act as bypass.
// - EXTEST, SAMPLE use chain; IDCODE uses identification.
// - BYPASS, HIGHZ, CLAMP shift through bypass bit.
// - Bypass is one bit, codes 100 to 111.
// - Reset selects identification register, not bypass.
// - Vendor test register: 8 bits, no capture, reset cleared.
// - Chain holds 29 cells in fixed order.
// - Input cells capture and shift, ignore update.
// - Output cells update; drive pin only under EXTEST or CLAMP.
// - One output cell controls each tristate group enable.
// - Bidirectional pins pair input cell with tristate control.
// - Identification: version, part, maker, bit zero one.
// - Maker field holds seven low bits only.
// - Version field starts at one, follows interface revisions.
// - No internal test or self-test through the port.
// - HIGHZ releases every output pin.
// - EXTEST or CLAMP: enables come from scan cells.
`include "bst_regs.svh"
`default_nettype none
module bst_tap #(
  parameter logic [3:0]  ID_VERSION = 4'h1,
  // Part number and maker code are arbitrary values.
  parameter logic [15:0] ID_PART    = 16'h0a5c,
  parameter logic [6:0]  ID_MAKER   = 7'h2b,
  parameter int          A_WIDTH    = 8
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_tck,
  input  wire logic               i_tms,
  input  wire logic               i_tdi,
  output var  logic               o_tdo,
  output var  logic               o_tdo_oe_n,
  input  wire logic [7:0]         i_pin_in,
  input  wire logic               i_sda_in,
  input  wire logic               i_func_sda,
  output var  logic               o_sda_out,
  output var  logic               o_sda_oe_n,
  input  wire logic               i_func_oel,
  input  wire logic               i_func_oel_en,
  output var  logic               o_output_enable_low_pin,
  output var  logic               o_output_enable_low_pin_oe_n,
  input  wire logic [A_WIDTH-1:0] i_a_in,
  input  wire logic [A_WIDTH-1:0] i_func_a,
  input  wire logic               i_func_a_en,
  output var  logic [A_WIDTH-1:0] o_a,
  output var  logic               o_a_oe_n,
  output var  logic [7:0]         o_vendor_test
);

  localparam int CL = `BST_CHAIN_LEN;

  if (`BST_POS_A_BASE + 2 * A_WIDTH != CL) begin : g_bad_width
    $error("A_WIDTH does not fit the 29-cell chain");
  end

  // Reset release into the test clock domain; assertion stays asynchronous.
  logic rst_t_meta_r;
  logic rst_t_r;
  always_ff @(posedge i_tck or posedge i_rst) begin
    if (i_rst) begin
      rst_t_meta_r <= 1'b1;
      rst_t_r      <= 1'b1;
    end else begin
      rst_t_meta_r <= 1'b0;
      rst_t_r      <= rst_t_meta_r;
    end
  end

  // TAP controller.
  bst_pkg::bst_tap_state_t st_r;
  bst_pkg::bst_tap_state_t st_nxt;

  always_comb begin
    case (st_r)
      bst_pkg::TLR:    st_nxt = i_tms ? bst_pkg::TLR    : bst_pkg::RTI;
      bst_pkg::RTI:    st_nxt = i_tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
      bst_pkg::SEL_DR: st_nxt = i_tms ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
      bst_pkg::CAP_DR: st_nxt = i_tms ? bst_pkg::EX1_DR : bst_pkg::SHF_DR;
      bst_pkg::SHF_DR: st_nxt = i_tms ? bst_pkg::EX1_DR : bst_pkg::SHF_DR;
      bst_pkg::EX1_DR: st_nxt = i_tms ? bst_pkg::UPD_DR : bst_pkg::PAU_DR;
      bst_pkg::PAU_DR: st_nxt = i_tms ? bst_pkg::EX2_DR : bst_pkg::PAU_DR;
      bst_pkg::EX2_DR: st_nxt = i_tms ? bst_pkg::UPD_DR : bst_pkg::SHF_DR;
      bst_pkg::UPD_DR: st_nxt = i_tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
      bst_pkg::SEL_IR: st_nxt = i_tms ? bst_pkg::TLR    : bst_pkg::CAP_IR;
      bst_pkg::CAP_IR: st_nxt = i_tms ? bst_pkg::EX1_IR : bst_pkg::SHF_IR;
      bst_pkg::SHF_IR: st_nxt = i_tms ? bst_pkg::EX1_IR : bst_pkg::SHF_IR;
      bst_pkg::EX1_IR: st_nxt = i_tms ? bst_pkg::UPD_IR : bst_pkg::PAU_IR;
      bst_pkg::PAU_IR: st_nxt = i_tms ? bst_pkg::EX2_IR : bst_pkg::PAU_IR;
      bst_pkg::EX2_IR: st_nxt = i_tms ? bst_pkg::UPD_IR : bst_pkg::SHF_IR;
      bst_pkg::UPD_IR: st_nxt = i_tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
      default:         st_nxt = bst_pkg::TLR;
    endcase
  end

  always_ff @(posedge i_tck or posedge rst_t_r) begin
    if (rst_t_r) begin
      st_r <= bst_pkg::TLR;
    end else begin
      st_r <= st_nxt;
    end
  end

  wire logic in_tlr = (st_r == bst_pkg::TLR);
  wire logic cap_dr = (st_r == bst_pkg::CAP_DR);
  wire logic shf_dr = (st_r == bst_pkg::SHF_DR);
  wire logic upd_dr = (st_r == bst_pkg::UPD_DR);
  wire logic cap_ir = (st_r == bst_pkg::CAP_IR);
  wire logic shf_ir = (st_r == bst_pkg::SHF_IR);
  wire logic upd_ir = (st_r == bst_pkg::UPD_IR);
  wire logic ir_branch = (st_r == bst_pkg::SEL_IR) || (st_r == bst_pkg::CAP_IR)
                      || shf_ir || (st_r == bst_pkg::EX1_IR)
                      || (st_r == bst_pkg::PAU_IR) || (st_r == bst_pkg::EX2_IR) || upd_ir;

  // Instruction register.
  logic [`BST_IR_LEN-1:0] ir_sr_r;
  logic [`BST_IR_LEN-1:0] ir_r;

  always_ff @(posedge i_tck or posedge rst_t_r) begin
    if (rst_t_r) begin
      ir_sr_r <= `BST_IR_CAPTURE;
    end else begin
      if (cap_ir) begin
        ir_sr_r <= `BST_IR_CAPTURE;
      end else if (shf_ir) begin
        ir_sr_r <= {i_tdi, ir_sr_r[`BST_IR_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge i_tck or posedge rst_t_r) begin
    if (rst_t_r) begin
      ir_r <= `BST_IR_IDCODE;
    end else begin
      if (in_tlr) begin
        ir_r <= `BST_IR_IDCODE;
      end else if (upd_ir) begin
        ir_r <= ir_sr_r;
      end
    end
  end

  // Decode; codes with the top bit set and no own meaning fall to bypass,
  // so no code reaches any internal or self-test path.
  wire logic sel_bsr = (ir_r == `BST_IR_EXTEST) || (ir_r == `BST_IR_SAMPLE);
  wire logic sel_id  = (ir_r == `BST_IR_IDCODE);
  wire logic sel_vt  = (ir_r == `BST_IR_VTEST);
  wire logic sel_byp = ir_r[2];
  wire logic md_ext  = (ir_r == `BST_IR_EXTEST);
  wire logic md_clp  = (ir_r == `BST_IR_CLAMP);
  wire logic md_hz   = (ir_r == `BST_IR_HIGHZ);

  // Pin observation: pins and the driven output flops pass two test-clock
  // flops before a cell captures them.
  logic [CL-1:0] obs;
  logic [CL-1:0] obs_meta_r;
  logic [CL-1:0] obs_r;

  always_comb begin
    obs = '0;
    obs[`BST_N_IN-1:0]      = i_pin_in;
    obs[`BST_POS_SDA_OUT]   = o_sda_oe_n;
    obs[`BST_POS_SDA_IN]    = i_sda_in;
    obs[`BST_POS_OEL_EN]    = ~o_output_enable_low_pin_oe_n;
    obs[`BST_POS_OEL_OUT]   = o_output_enable_low_pin;
    obs[`BST_POS_A_EN]      = ~o_a_oe_n;
    for (int i = 0; i < A_WIDTH; i++) begin
      obs[`BST_POS_A_BASE + 2 * i]     = o_a[i];
      obs[`BST_POS_A_BASE + 2 * i + 1] = i_a_in[i];
    end
  end

  always_ff @(posedge i_tck or posedge rst_t_r) begin
    if (rst_t_r) begin
      obs_meta_r <= '0;
      obs_r      <= '0;
    end else begin
      obs_meta_r <= obs;
      obs_r      <= obs_meta_r;
    end
  end

  // Data registers.
  logic [CL-1:0]           bsr_sr_r;
  logic [CL-1:0]           upd_r;
  logic [`BST_ID_LEN-1:0]  id_sr_r;
  logic                    byp_r;
  logic [`BST_VT_LEN-1:0]  vt_sr_r;
  logic                    evt_t_r;

  wire logic [`BST_ID_LEN-1:0] id_word =
    {ID_VERSION, ID_PART, `BST_ID_PAD, ID_MAKER, 1'b1};
  wire logic [CL-1:0] out_mask = `BST_OUT_MASK;
  wire logic evt_req = upd_dr || upd_ir || (in_tlr && (ir_r != `BST_IR_IDCODE));

  always_ff @(posedge i_tck or posedge rst_t_r) begin
    if (rst_t_r) begin
      bsr_sr_r <= '0;
    end else begin
      if (cap_dr && sel_bsr) begin
        bsr_sr_r <= obs_r;
      end else if (shf_dr && sel_bsr) begin
        bsr_sr_r <= {i_tdi, bsr_sr_r[CL-1:1]};
      end
    end
  end

  always_ff @(posedge i_tck or posedge rst_t_r) begin
    if (rst_t_r) begin
      upd_r <= '0;
    end else begin
      if (upd_dr && sel_bsr) begin
        upd_r <= (upd_r & ~out_mask) | (bsr_sr_r & out_mask);
      end
    end
  end

  always_ff @(posedge i_tck or posedge rst_t_r) begin
    if (rst_t_r) begin
      id_sr_r <= '0;
    end else begin
      if (cap_dr && sel_id) begin
        id_sr_r <= id_word;
      end else if (shf_dr && sel_id) begin
        id_sr_r <= {i_tdi, id_sr_r[`BST_ID_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge i_tck or posedge rst_t_r) begin
    if (rst_t_r) begin
      byp_r <= 1'b0;
    end else begin
      if (cap_dr && sel_byp) begin
        byp_r <= `BST_BYP_CAPTURE;
      end else if (shf_dr && sel_byp) begin
        byp_r <= i_tdi;
      end
    end
  end

  // A toggle per update lets the pin side reload mode and flops together.
  always_ff @(posedge i_tck or posedge rst_t_r) begin
    if (rst_t_r) begin
      evt_t_r <= 1'b0;
    end else begin
      if (evt_req) begin
        evt_t_r <= ~evt_t_r;
      end
    end
  end

  // Vendor test register has no capture, so the last shifted word returns.
  // Only power-on reset clears it; Test-Logic-Reset leaves it alone.
  always_ff @(posedge i_tck or posedge rst_t_r) begin
    if (rst_t_r) begin
      vt_sr_r <= `BST_VT_RESET;
    end else begin
      if (shf_dr && sel_vt) begin
        vt_sr_r <= {i_tdi, vt_sr_r[`BST_VT_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge i_tck or posedge rst_t_r) begin
    if (rst_t_r) begin
      o_vendor_test <= `BST_VT_RESET;
    end else begin
      if (upd_dr && sel_vt) begin
        o_vendor_test <= vt_sr_r;
      end
    end
  end

  // Serial output path and falling-edge output stage.
  wire logic dr_bit = sel_bsr ? bsr_sr_r[0] :
                      sel_id  ? id_sr_r[0]  :
                      sel_vt  ? vt_sr_r[0]  : byp_r;
  wire logic tdo_bit = ir_branch ? ir_sr_r[0] : dr_bit;
  wire logic tdo_act = shf_dr || shf_ir;

  always_ff @(negedge i_tck or posedge rst_t_r) begin
    if (rst_t_r) begin
      o_tdo      <= 1'b0;
      o_tdo_oe_n <= 1'b1;
    end else begin
      o_tdo      <= tdo_bit;
      o_tdo_oe_n <= ~tdo_act;
    end
  end

  // Update flops and instruction cross to the system clock with a toggle.
  // The words stay put for at least three test clocks after the toggle,
  // which outlasts the three system clocks the toggle takes to arrive.
  logic          evt_s1_r;
  logic          evt_s2_r;
  logic          evt_s3_r;
  logic [CL-1:0] upd_c_r;
  logic          ext_c_r;
  logic          clp_c_r;
  logic          hz_c_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      evt_s1_r <= 1'b0;
      evt_s2_r <= 1'b0;
      evt_s3_r <= 1'b0;
    end else begin
      evt_s1_r <= evt_t_r;
      evt_s2_r <= evt_s1_r;
      evt_s3_r <= evt_s2_r;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      upd_c_r  <= '0;
      ext_c_r  <= 1'b0;
      clp_c_r  <= 1'b0;
      hz_c_r   <= 1'b0;
    end else begin
      if (evt_s2_r != evt_s3_r) begin
        upd_c_r <= upd_r;
        ext_c_r <= md_ext;
        clp_c_r <= md_clp;
        hz_c_r  <= md_hz;
      end
    end
  end

  // Pin drive: HIGHZ first, then scan control under EXTEST or CLAMP,
  // else the functional path.
  wire logic          bs_ctl  = ext_c_r || clp_c_r;
  wire logic [A_WIDTH-1:0] a_scan;
  for (genvar g = 0; g < A_WIDTH; g++) begin : g_a
    assign a_scan[g] = upd_c_r[`BST_POS_A_BASE + 2 * g];
  end
  wire logic [A_WIDTH-1:0] a_nxt = bs_ctl ? a_scan : i_func_a;
  wire logic a_en_nxt   = bs_ctl ? upd_c_r[`BST_POS_A_EN] : i_func_a_en;
  wire logic oel_nxt    = bs_ctl ? upd_c_r[`BST_POS_OEL_OUT] : i_func_oel;
  wire logic oel_en_nxt = bs_ctl ? upd_c_r[`BST_POS_OEL_EN] : i_func_oel_en;
  wire logic sda_nxt    = bs_ctl ? upd_c_r[`BST_POS_SDA_OUT] : i_func_sda;
  wire logic a_oe_n_nxt   = hz_c_r || !a_en_nxt;
  wire logic oel_oe_n_nxt = hz_c_r || !oel_en_nxt;
  wire logic sda_oe_n_nxt = hz_c_r || sda_nxt;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_a                          <= '0;
      o_a_oe_n                     <= 1'b1;
      o_output_enable_low_pin      <= 1'b0;
      o_output_enable_low_pin_oe_n <= 1'b1;
      o_sda_out                    <= 1'b0;
      o_sda_oe_n                   <= 1'b1;
    end else begin
      o_a                          <= a_nxt;
      o_a_oe_n                     <= a_oe_n_nxt;
      o_output_enable_low_pin      <= oel_nxt;
      o_output_enable_low_pin_oe_n <= oel_oe_n_nxt;
      o_sda_out                    <= 1'b0;
      o_sda_oe_n                   <= sda_oe_n_nxt;
    end
  end

endmodule // bst_tap
`default_nettype wire

//--- sim/bst_tap_monitor.sv
// Pin-level checks on the boundary-scan test port.
`default_nettype none
module bst_chk #(
  parameter int A_WIDTH = 8
) (
  input wire logic               i_clk,
  input wire logic               i_rst,
  input wire logic               i_tck,
  input wire logic               i_tms,
  input wire logic               o_tdo_oe_n,
  input wire logic               o_sda_out,
  input wire logic               o_sda_oe_n,
  input wire logic               o_output_enable_low_pin_oe_n,
  input wire logic [A_WIDTH-1:0] o_a,
  input wire logic               o_a_oe_n,
  input wire logic [7:0]         o_vendor_test
);
  AST_RST_HIZ: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(i_rst) |-> o_a_oe_n && o_sda_oe_n && o_output_enable_low_pin_oe_n)
    else $error("Output enabled out of reset");
  AST_RST_VAL: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(i_rst) |-> o_vendor_test == 8'h00 && o_a == '0)
    else $error("Reset values wrong");
  AST_RST_TDO: assert property (@(posedge i_tck) disable iff (i_rst)
    $fell(i_rst) |-> o_tdo_oe_n [*4])
    else $error("Data out driven too soon after reset");
  AST_SDA_OD: assert property (@(posedge i_clk) disable iff (i_rst)
    o_sda_out == 1'b0)
    else $error("Open-drain pin driven high");
  AST_TDO_OFF: assert property (@(posedge i_tck) disable iff (i_rst)
    i_tms |=> o_tdo_oe_n)
    else $error("Data out driven outside shift");
  AST_TDO_STAY: assert property (@(posedge i_tck) disable iff (i_rst)
    !o_tdo_oe_n && !i_tms |=> !o_tdo_oe_n)
    else $error("Shift left without mode select");
  AST_TDO_ENTER: assert property (@(posedge i_tck) disable iff (i_rst)
    $fell(o_tdo_oe_n) |-> !$past(i_tms))
    else $error("Shift entered on a high mode select");
  AST_VT_UPD: assert property (@(posedge i_tck) disable iff (i_rst)
    $changed(o_vendor_test) |-> $past(i_tms) || $past(i_tms, 2))
    else $error("Test register changed outside update");
  COV_VT: cover property (@(posedge i_tck) $changed(o_vendor_test));
  COV_SHIFT: cover property (@(posedge i_tck) $fell(o_tdo_oe_n));
  COV_HIZ: cover property (@(posedge i_clk) $rose(o_a_oe_n));
endmodule // bst_chk
bind bst_tap bst_chk #(.A_WIDTH(A_WIDTH)) bst_chk_inst (.i_clk, .i_rst, .i_tck, .i_tms,
  .o_tdo_oe_n, .o_sda_out, .o_sda_oe_n, .o_output_enable_low_pin_oe_n, .o_a, .o_a_oe_n,
  .o_vendor_test);
`default_nettype wire

//--- sim/bst_tck_host.sv
// Tester model that drives the test clock, mode select and data in.
`default_nettype none
module bst_tck_host (
  output var  logic o_tck,
  output var  logic o_tms,
  output var  logic o_tdi,
  input  wire logic i_tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // The clock stands low between steps, and no reset pin exists.
  task automatic step(input logic m, input logic d, output logic q);
    o_tms = m;
    o_tdi = d;
    #40 o_tck = 1'b1;
    q = i_tdo;
    #40 o_tck = 1'b0;
  endtask
  task automatic reset_tap();
    logic q;
    repeat (6) step(1'b1, !o_tdi, q);
    step(1'b0, !o_tdi, q);
  endtask
  // Data in toggles when unused, so a stale level never looks valid.
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, !o_tdi, q);
    if (ir) step(1'b1, !o_tdi, q);
    step(1'b0, !o_tdi, q);
    step(1'b0, !o_tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, !o_tdi, q);
    step(1'b0, !o_tdi, q);
  endtask
endmodule // bst_tck_host
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the boundary-scan test port.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID_EXP = {4'h1, 16'h0a5c, 4'h0, 7'h2b, 1'h1};
  logic        i_clk, i_rst, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe_n, i_sda_in;
  logic        i_func_sda, o_sda_out, o_sda_oe_n, i_func_oel, i_func_oel_en, i_func_a_en;
  logic        o_output_enable_low_pin, o_output_enable_low_pin_oe_n, o_a_oe_n;
  logic [7:0]  i_pin_in, i_a_in, i_func_a, o_a, o_vendor_test;
  logic [31:0] dout;
  int          err_total, cmp_count, cyc;
  // Part and maker values are arbitrary.
  bst_tap #(.ID_VERSION(4'h1), .ID_PART(16'h0a5c), .ID_MAKER(7'h2b), .A_WIDTH(8))
    bst_tap_inst (.i_clk, .i_rst, .i_tck, .i_tms, .i_tdi, .o_tdo, .o_tdo_oe_n, .i_pin_in,
    .i_sda_in, .i_func_sda, .o_sda_out, .o_sda_oe_n, .i_func_oel, .i_func_oel_en,
    .o_output_enable_low_pin, .o_output_enable_low_pin_oe_n, .i_a_in, .i_func_a,
    .i_func_a_en, .o_a, .o_a_oe_n, .o_vendor_test);
  bst_tck_host bst_tck_host_inst (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo));
  always #20 i_clk = ~i_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic set_ir(input logic [2:0] code);
    bst_tck_host_inst.scan(1'b1, 5, {27'h0, code, 2'h2}, dout);
    chk(dout[4:0], 5'h15);
  endtask
  task automatic pins(input logic [2:0] oe);
    repeat (6) @(negedge i_clk);
    chk({o_a_oe_n, o_output_enable_low_pin_oe_n, o_sda_oe_n}, oe);
  endtask
  task automatic t_idcode();
    bst_tck_host_inst.scan(1'b0, 32, 32'h0, dout);
    chk(dout, ID_EXP);
    chk(o_tdo_oe_n, 1'b1);
    $display("Identification test done");
  endtask
  task automatic t_chain();
    set_ir(3'h1);
    bst_tck_host_inst.scan(1'b0, 32, {29'haa1d00, 3'h5}, dout);
    chk(dout[28:0], 29'h18c732c5);
    chk(dout[31:29], 3'h5);
    set_ir(3'h0);
    pins(3'h1);
    chk(o_a, 8'h3c);
    chk(o_output_enable_low_pin, 1'b1);
    $display("Chain test done");
  endtask
  task automatic t_bypass();
    for (int c = 4; c < 8; c++) begin
      set_ir(c[2:0]);
      bst_tck_host_inst.scan(1'b0, 9, 32'h0b5, dout);
      chk(dout[8:0], 9'h16a);
      pins(c == 4 ? 3'h7 : c == 6 ? 3'h1 : 3'h2);
      if (c == 6) chk(o_a, 8'h3c);
      if (c[0]) chk(o_a, 8'ha5);
    end
    $display("Bypass test done");
  endtask
  task automatic t_vendor();
    set_ir(3'h3);
    // A tester in service leaves this register alone; here it is loaded on purpose.
    bst_tck_host_inst.scan(1'b0, 8, 32'h5a, dout);
    chk(dout[7:0], 8'h00);
    bst_tck_host_inst.scan(1'b0, 8, 32'h3c, dout);
    chk(dout[7:0], 8'h5a);
    chk(o_vendor_test, 8'h3c);
    $display("Vendor test done");
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_pin_in = 8'hc5;
    i_sda_in = 1'b1;
    i_func_sda = 1'b0;
    i_func_oel = 1'b0;
    i_func_oel_en = 1'b0;
    i_a_in = 8'h96;
    i_func_a = 8'ha5;
    i_func_a_en = 1'b1;
    fork
      begin
        repeat (4) @(posedge i_clk);
        @(negedge i_clk) i_rst = 1'b0;
      end
      bst_tck_host_inst.reset_tap();
    join
    t_idcode();
    t_chain();
    t_bypass();
    t_vendor();
    bst_tck_host_inst.reset_tap();
    t_idcode();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
